// ---- core/nsoc_pkg.sv ----
// constants and types of the negative sequence overcurrent timer
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package nsoc_pkg;

  // ----------------------------------------------------------------------
  // register map, word indices on the plain register port
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_OPER   = 4'h0;
  localparam logic [3:0] REG_LEVEL  = 4'h1;
  localparam logic [3:0] REG_TMS    = 4'h2;
  localparam logic [3:0] REG_MINDLY = 4'h3;
  localparam logic [3:0] REG_DEFDLY = 4'h4;
  localparam logic [3:0] REG_RSTDLY = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_MEAS   = 4'h7;

  // ----------------------------------------------------------------------
  // setting ranges and reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] LEVEL_MIN   = 16'h000a;  // 10 %
  localparam logic [15:0] LEVEL_MAX   = 16'h03e8;  // 1000 %
  localparam logic [15:0] LEVEL_RST   = 16'h0032;  // 50 %
  localparam logic [15:0] TMS_MIN     = 16'h0005;  // 0.05 in hundredths
  localparam logic [15:0] TMS_MAX     = 16'h05dc;  // 15.00
  localparam logic [15:0] TMS_RST     = 16'h0064;  // 1.00
  localparam logic [15:0] DLY_MIN     = 16'h0028;  // 40 ms
  localparam logic [15:0] RSTDLY_MIN  = 16'h003c;  // 60 ms
  localparam logic [15:0] DLY_MAX     = 16'hea60;  // 60000 ms
  localparam logic [15:0] DLY_RST     = 16'h0064;  // 100 ms

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_TIME_NS  = 1000000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam logic [31:0] PCT_SCALE = 32'h00000064;  // hundredths per unit

  // ratio breakpoints in tenths of the start level
  localparam int NUM_BANDS = 8;
  localparam logic [7:0] BAND_TENTHS [NUM_BANDS] = '{
    8'h0b, 8'h0f, 8'h14, 8'h1e, 8'h32, 8'h46, 8'h64, 8'hc8};
  localparam logic [23:0] TENTHS = 24'h00000a;

  // ----------------------------------------------------------------------
  // operation selector codes
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_OFF          = 4'h0,
    OP_FIXED_DELAY  = 4'h1,
    OP_IEC_INV      = 4'h2,
    OP_IEC_VINV     = 4'h3,
    OP_IEC_EINV     = 4'h4,
    OP_IEC_LINV     = 4'h5,
    OP_ANSI_INV     = 4'h6,
    OP_ANSI_MINV    = 4'h7,
    OP_ANSI_VINV    = 4'h8,
    OP_ANSI_EINV    = 4'h9,
    OP_ANSI_LINV    = 4'ha,
    OP_ANSI_LVINV   = 4'hb,
    OP_ANSI_LEINV   = 4'hc
  } nsoc_oper_t;

  localparam logic [3:0] OP_LAST = 4'hc;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN  = 4'b0010,
    ST_HOLD = 4'b0100,
    ST_TRIP = 4'b1000
  } nsoc_state_t;

endpackage : nsoc_pkg

// ---- core/nsoc_ms_tick.sv ----
// one millisecond timebase pulse generator
`timescale 1ns/1ps
module nsoc_ms_tick
  import nsoc_pkg::*;
#(
  parameter int CYCLES = 20000
) (
  input  wire logic clk,    // system clock
  input  wire logic rst,    // synchronous reset, active high
  output logic      tick    // one-cycle pulse every CYCLES clocks
);

  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_tick;

  always_comb begin
    next_tick  = 1'b0;
    next_count = count + 32'h00000001;
    if (count >= 32'(CYCLES - 1)) begin
      next_count = 32'h00000000;
      next_tick  = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 32'h00000000;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

endmodule : nsoc_ms_tick

// ---- core/nsoc_timer.sv ----
// negative sequence overcurrent start and trip timer
`timescale 1ns/1ps
module nsoc_timer
  import nsoc_pkg::*;
#(
  parameter int MS_CYCLES = TICK_CYCLES
) (
  input  wire logic        REF_CLK,                  // system clock
  input  wire logic        RST,                      // sync reset, high
  input  wire logic [15:0] NEG_SEQ_FUNDAMENTAL_MAG,  // magnitude in %
  input  wire logic        FUNCTION_BLOCK_INPUT,     // user block, high
  input  wire logic [3:0]  REG_ADDR,                 // register index
  input  wire logic [15:0] REG_WDATA,                // write data
  input  wire logic        REG_WR,                   // write strobe
  input  wire logic        REG_RD,                   // read strobe
  output logic      [15:0] REG_RDATA,                // read data, next cycle
  output logic             GENERAL_START_OUT,        // general start
  output logic             GENERAL_TRIP_OUT          // general trip
);

  // ----------------------------------------------------------------------
  // base operate times in ms at multiplier 1.00, per curve and ratio band
  // ----------------------------------------------------------------------
  localparam logic [20:0] CURVE_MS [88] = '{
    21'd73374,  21'd17194,  21'd10029, 21'd6301,
    21'd4280,   21'd3527,   21'd2971,  21'd2268,
    21'd135000, 21'd27000,  21'd13500, 21'd6750,
    21'd3375,   21'd2250,   21'd1500,  21'd711,
    21'd380952, 21'd64000,  21'd26667, 21'd10000,
    21'd3333,   21'd1667,   21'd808,   21'd201,
    21'd1200000, 21'd240000, 21'd120000, 21'd60000,
    21'd30000,  21'd20000,  21'd13333, 21'd6316,
    21'd4526,   21'd1075,   21'd635,   21'd406,
    21'd281,    21'd235,    21'd201,   21'd158,
    21'd27106,  21'd6439,   21'd3803,  21'd2432,
    21'd1688,   21'd1411,   21'd1207,  21'd948,
    21'd93871,  21'd16179,  21'd7028,  21'd2942,
    21'd1308,   21'd900,    21'd689,   21'd540,
    21'd134408, 21'd22682,  21'd9522,  21'd3647,
    21'd1297,   21'd709,    21'd407,   21'd192,
    21'd45256,  21'd10748,  21'd6346,  21'd4056,
    21'd2814,   21'd2351,   21'd2010,  21'd1578,
    21'd136664, 21'd23552,  21'd10229, 21'd4281,
    21'd1902,   21'd1307,   21'd1000,  21'd784,
    21'd305350, 21'd51506,  21'd21607, 21'd8259,
    21'd2920,   21'd1585,   21'd897,   21'd411
  };

  localparam logic [24:0] ELAPSED_MAX = 25'h1ffffff;
  localparam logic [24:0] ONE_MS      = 25'h0000001;
  localparam logic [15:0] HOLD_ONE    = 16'h0001;

  // ----------------------------------------------------------------------
  // clamp of a written setting into its range
  // ----------------------------------------------------------------------
  function automatic logic [15:0] clamp16(input logic [15:0] val,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic [15:0] res;
    res = val;
    if (val < lo) begin
      res = lo;
    end else if (val > hi) begin
      res = hi;
    end
    return res;
  endfunction : clamp16

  // ----------------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------------
  logic [3:0]  operation_curve_select;
  logic [15:0] start_level_percent;
  logic [15:0] inverse_time_multiplier;
  logic [15:0] inverse_min_delay_ms;
  logic [15:0] definite_delay_ms;
  logic [15:0] inverse_reset_delay_ms;
  logic [3:0]  next_oper;
  logic [15:0] next_level;
  logic [15:0] next_tms;
  logic [15:0] next_mindly;
  logic [15:0] next_defdly;
  logic [15:0] next_rstdly;
  logic [15:0] next_rdata;

  // unknown selector codes are refused so the timer never sees them
  always_comb begin
    next_oper   = operation_curve_select;
    next_level  = start_level_percent;
    next_tms    = inverse_time_multiplier;
    next_mindly = inverse_min_delay_ms;
    next_defdly = definite_delay_ms;
    next_rstdly = inverse_reset_delay_ms;
    if (REG_WR) begin
      unique case (REG_ADDR)
        REG_OPER: begin
          if (REG_WDATA[3:0] <= OP_LAST) begin
            next_oper = REG_WDATA[3:0];
          end
        end
        REG_LEVEL: begin
          next_level = clamp16(REG_WDATA, LEVEL_MIN, LEVEL_MAX);
        end
        REG_TMS: begin
          next_tms = clamp16(REG_WDATA, TMS_MIN, TMS_MAX);
        end
        REG_MINDLY: begin
          next_mindly = clamp16(REG_WDATA, DLY_MIN, DLY_MAX);
        end
        REG_DEFDLY: begin
          next_defdly = clamp16(REG_WDATA, DLY_MIN, DLY_MAX);
        end
        REG_RSTDLY: begin
          next_rstdly = clamp16(REG_WDATA, RSTDLY_MIN, DLY_MAX);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      operation_curve_select  <= OP_OFF;
      start_level_percent     <= LEVEL_RST;
      inverse_time_multiplier <= TMS_RST;
      inverse_min_delay_ms    <= DLY_RST;
      definite_delay_ms       <= DLY_RST;
      inverse_reset_delay_ms  <= DLY_RST;
    end else begin
      operation_curve_select  <= next_oper;
      start_level_percent     <= next_level;
      inverse_time_multiplier <= next_tms;
      inverse_min_delay_ms    <= next_mindly;
      definite_delay_ms       <= next_defdly;
      inverse_reset_delay_ms  <= next_rstdly;
    end
  end

  // ----------------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------------
  logic ms_tick;

  nsoc_ms_tick #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .clk  (REF_CLK),
    .rst  (RST),
    .tick (ms_tick)
  );

  // ----------------------------------------------------------------------
  // level comparison and ratio band
  // ----------------------------------------------------------------------
  logic                 active;
  logic                 start_cond;
  logic                 is_fixed;
  logic [NUM_BANDS-1:0] band_hit;
  logic [2:0]           band;
  logic [3:0]           curve_idx;
  logic [20:0]          base_ms;
  logic [23:0]          mag_tenths;

  // off or blocked leaves nothing running
  assign active   = (operation_curve_select != OP_OFF)
                    && !FUNCTION_BLOCK_INPUT;
  assign is_fixed = (operation_curve_select == OP_FIXED_DELAY);
  assign start_cond = active
                      && (NEG_SEQ_FUNDAMENTAL_MAG > start_level_percent);
  assign mag_tenths = {8'h00, NEG_SEQ_FUNDAMENTAL_MAG} * TENTHS;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANDS; gi++) begin : g_band
      assign band_hit[gi] = mag_tenths >=
        ({8'h00, start_level_percent} * {16'h0000, BAND_TENTHS[gi]});
    end
  endgenerate

  // band 0 also covers 1.0..1.1, so operation above 1.0 is certain
  always_comb begin
    band = 3'h0;
    for (int i = 1; i < NUM_BANDS; i++) begin
      if (band_hit[i]) begin
        band = 3'(i);
      end
    end
  end

  assign curve_idx = operation_curve_select - OP_IEC_INV;
  assign base_ms   = CURVE_MS[7'({curve_idx, band})];

  // ----------------------------------------------------------------------
  // operate timing
  // ----------------------------------------------------------------------
  nsoc_state_t state;
  nsoc_state_t next_state;
  logic [24:0] elapsed;
  logic [24:0] next_elapsed;
  logic [15:0] hold_ms;
  logic [15:0] next_hold_ms;
  logic [31:0] elapsed_pct;
  logic [31:0] target_pct;
  logic        delay_done;
  logic        internal_start_flag;
  logic        internal_trip_flag;

  // compare scaled by 100 rather than divide the multiplier product
  assign elapsed_pct = {7'h00, elapsed} * PCT_SCALE;
  assign target_pct  = {11'h000, base_ms} * {16'h0000,
                                             inverse_time_multiplier};

  always_comb begin
    if (is_fixed) begin
      delay_done = elapsed >= {9'h000, definite_delay_ms};
    end else begin
      delay_done = (elapsed >= {9'h000, inverse_min_delay_ms})
                   && (elapsed_pct >= target_pct);
    end
  end

  always_comb begin
    next_state   = state;
    next_elapsed = elapsed;
    next_hold_ms = hold_ms;
    unique case (state)
      ST_IDLE: begin
        next_elapsed = '0;
        next_hold_ms = '0;
        if (start_cond) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!active) begin
          next_state = ST_IDLE;
        end else if (!start_cond) begin
          next_hold_ms = '0;
          next_state   = is_fixed ? ST_IDLE : ST_HOLD;
        end else if (delay_done) begin
          next_state = ST_TRIP;
        end else if (ms_tick && elapsed != ELAPSED_MAX) begin
          next_elapsed = elapsed + ONE_MS;
        end
      end
      ST_HOLD: begin
        // inverse timing is kept for the reset delay, then forgotten
        if (!active) begin
          next_state = ST_IDLE;
        end else if (start_cond) begin
          next_state = ST_RUN;
        end else if (hold_ms >= inverse_reset_delay_ms) begin
          next_state = ST_IDLE;
        end else if (ms_tick) begin
          next_hold_ms = hold_ms + HOLD_ONE;
        end
      end
      ST_TRIP: begin
        if (!start_cond) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state   <= ST_IDLE;
      elapsed <= '0;
      hold_ms <= '0;
    end else begin
      state   <= next_state;
      elapsed <= next_elapsed;
      hold_ms <= next_hold_ms;
    end
  end

  // ----------------------------------------------------------------------
  // decision logic
  // ----------------------------------------------------------------------
  assign internal_start_flag = start_cond;
  assign internal_trip_flag  = start_cond
                               && (next_state == ST_TRIP);

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      GENERAL_START_OUT <= 1'b0;
      GENERAL_TRIP_OUT  <= 1'b0;
    end else begin
      GENERAL_START_OUT <= internal_start_flag;
      GENERAL_TRIP_OUT  <= internal_trip_flag;
    end
  end

  // ----------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------
  always_comb begin
    next_rdata = 16'h0000;
    if (REG_RD) begin
      unique case (REG_ADDR)
        REG_OPER:   next_rdata = {12'h000, operation_curve_select};
        REG_LEVEL:  next_rdata = start_level_percent;
        REG_TMS:    next_rdata = inverse_time_multiplier;
        REG_MINDLY: next_rdata = inverse_min_delay_ms;
        REG_DEFDLY: next_rdata = definite_delay_ms;
        REG_RSTDLY: next_rdata = inverse_reset_delay_ms;
        REG_STATUS: next_rdata = {4'h0, state, 1'b0, band, 1'b0,
                                  FUNCTION_BLOCK_INPUT,
                                  GENERAL_TRIP_OUT, GENERAL_START_OUT};
        REG_MEAS:   next_rdata = NEG_SEQ_FUNDAMENTAL_MAG;
        default:    next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      REG_RDATA <= 16'h0000;
    end else begin
      REG_RDATA <= next_rdata;
    end
  end

endmodule : nsoc_timer

// ---- verification/nsoc_timer_sva.sv ----
// assertion checker for the negative sequence overcurrent timer
`timescale 1ns/1ps
module nsoc_timer_sva
  import nsoc_pkg::*;
#(
  parameter int MS_CYCLES = TICK_CYCLES
) (
  input wire logic        REF_CLK,                  // system clock
  input wire logic        RST,                      // sync reset
  input wire logic [15:0] NEG_SEQ_FUNDAMENTAL_MAG,  // magnitude
  input wire logic        FUNCTION_BLOCK_INPUT,     // block
  input wire logic [3:0]  REG_ADDR,                 // register index
  input wire logic [15:0] REG_WDATA,                // write data
  input wire logic        REG_WR,                   // write strobe
  input wire logic        REG_RD,                   // read strobe
  input wire logic [15:0] REG_RDATA,                // read data
  input wire logic        GENERAL_START_OUT,        // general start
  input wire logic        GENERAL_TRIP_OUT          // general trip
);
  // --------------------------------------------------------------------
  // started time since the last block; a tick of slack for phase
  // --------------------------------------------------------------------
  localparam int MIN_RUN = (int'(DLY_MIN) - 1) * MS_CYCLES - 2;
  int run_len;
  int next_run_len;

  always_comb begin
    next_run_len = FUNCTION_BLOCK_INPUT ? 0 : run_len + int'(GENERAL_START_OUT);
  end

  always_ff @(posedge REF_CLK) begin
    run_len <= RST ? 0 : next_run_len;
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  chk_reset_quiet: assert property ($past(RST) |->
    !GENERAL_START_OUT && !GENERAL_TRIP_OUT) else $error("outputs after reset");
  chk_block_start: assert property (FUNCTION_BLOCK_INPUT |=>
    !GENERAL_START_OUT) else $error("start while blocked");
  chk_block_trip: assert property (FUNCTION_BLOCK_INPUT |=>
    !GENERAL_TRIP_OUT) else $error("trip while blocked");
  chk_below_level: assert property (NEG_SEQ_FUNDAMENTAL_MAG <= LEVEL_MIN
    |=> !GENERAL_START_OUT) else $error("start below level");
  chk_start_cause: assert property ($rose(GENERAL_START_OUT) |->
    $past(NEG_SEQ_FUNDAMENTAL_MAG > LEVEL_MIN && !FUNCTION_BLOCK_INPUT))
    else $error("start without cause");
  chk_trip_started: assert property ($rose(GENERAL_TRIP_OUT) |->
    GENERAL_START_OUT) else $error("trip without start");
  chk_trip_early: assert property ($rose(GENERAL_TRIP_OUT) |->
    run_len >= MIN_RUN) else $error("trip too early");
  chk_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 16'h0000)
    else $error("read data outside read");
  chk_unmapped_read: assert property (REG_RD && REG_ADDR[3] |=>
    REG_RDATA == 16'h0000) else $error("unmapped read not zero");

  cover property ($rose(GENERAL_TRIP_OUT));
  cover property (FUNCTION_BLOCK_INPUT && GENERAL_START_OUT);
  cover property (REG_RD ##1 REG_RDATA != 16'h0000);
endmodule : nsoc_timer_sva

bind nsoc_timer nsoc_timer_sva #(.MS_CYCLES(MS_CYCLES)) nsoc_timer_sva_inst (
  .REF_CLK(REF_CLK), .RST(RST),
  .NEG_SEQ_FUNDAMENTAL_MAG(NEG_SEQ_FUNDAMENTAL_MAG),
  .FUNCTION_BLOCK_INPUT(FUNCTION_BLOCK_INPUT), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .GENERAL_START_OUT(GENERAL_START_OUT),
  .GENERAL_TRIP_OUT(GENERAL_TRIP_OUT));

// ---- verification/nsoc_meas_model.sv ----
// upstream measurement stage and user block logic model
`timescale 1ns/1ps
module nsoc_meas_model (
  input  wire logic        clk,         // system clock
  input  wire logic        rst,         // sync reset
  input  wire logic [15:0] target_mag,  // commanded magnitude
  input  wire logic        block_req,   // commanded block
  output logic      [15:0] mag,         // negative sequence magnitude
  output logic             block        // user block level
);
  logic [15:0] next_mag;
  logic        next_block;

  // one register stage, as the upstream result updates on a clock
  always_comb begin
    next_mag   = rst ? 16'h0000 : target_mag;
    next_block = rst ? 1'b0 : block_req;
  end

  always_ff @(posedge clk) begin
    mag   <= next_mag;
    block <= next_block;
  end
endmodule : nsoc_meas_model

// ---- verification/tb.sv ----
// self-checking testbench of the negative sequence overcurrent timer
`timescale 1ns/1ps
module tb;
  import nsoc_pkg::*;
  localparam int MS = 20;
  logic        ref_clk;
  logic        rst;
  logic [15:0] tgt_mag;
  logic        blk_req;
  logic [15:0] mag;
  logic        blk;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        start_out;
  logic        trip_out;
  int          failures;
  int          check_count;
  int          n;

  nsoc_meas_model nsoc_meas_model_inst (.clk(ref_clk), .rst(rst),
    .target_mag(tgt_mag), .block_req(blk_req), .mag(mag), .block(blk));
  nsoc_timer #(.MS_CYCLES(MS)) nsoc_timer_inst (.REF_CLK(ref_clk),
    .RST(rst), .NEG_SEQ_FUNDAMENTAL_MAG(mag), .FUNCTION_BLOCK_INPUT(blk),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .GENERAL_START_OUT(start_out), .GENERAL_TRIP_OUT(trip_out));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // --------------------------------------------------------------------
  // access and compare tasks
  // --------------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd_check(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : rd_check

  task automatic wr_check(input logic [3:0] a, input logic [15:0] d,
                          input logic [15:0] exp);
    wr(a, d);
    rd_check(a, exp);
  endtask : wr_check

  task automatic cycles(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : cycles

  // bounded wait; running out ends the run as a failure
  task automatic wait_trip(input int lim, output int cnt);
    cnt = 0;
    while (trip_out !== 1'b1 && cnt < lim) begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end
    if (cnt >= lim) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
      finish_test();
    end
  endtask : wait_trip

  task automatic in_range(input int v, input int lo, input int hi);
    check({15'h0000, v >= lo && v <= hi}, 16'h0001);
  endtask : in_range

  task automatic rearm(input logic [3:0] a, input logic [15:0] d);
    blk_req <= 1'b1;
    wr(a, d);
    cycles(3);
    check({14'h0000, start_out, trip_out}, 16'h0000);
    blk_req <= 1'b0;
  endtask : rearm

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    tgt_mag = 16'h0000;
    blk_req = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    failures = 0;
    check_count = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd_check(REG_OPER, 16'h0000);
    rd_check(REG_LEVEL, LEVEL_RST);
    rd_check(REG_TMS, TMS_RST);
    rd_check(REG_MINDLY, DLY_RST);
    rd_check(REG_DEFDLY, DLY_RST);
    rd_check(REG_RSTDLY, DLY_RST);
    rd_check(4'h9, 16'h0000);
    tgt_mag <= 16'h03e8;
    cycles(3 * MS);
    check({14'h0000, start_out, trip_out}, 16'h0000);
    rd_check(REG_MEAS, 16'h03e8);
    tgt_mag <= 16'h0000;
    for (int i = 1; i <= 12; i++) begin
      wr_check(REG_OPER, 16'(i), 16'(i));
    end
    wr_check(REG_OPER, 16'h000d, 16'h000c);
    wr_check(REG_LEVEL, 16'h0005, LEVEL_MIN);
    wr_check(REG_LEVEL, 16'h07d0, LEVEL_MAX);
    wr_check(REG_TMS, 16'h0000, TMS_MIN);
    wr_check(REG_TMS, 16'hffff, TMS_MAX);
    wr_check(REG_MINDLY, 16'h0027, DLY_MIN);
    wr_check(REG_DEFDLY, 16'hffff, DLY_MAX);
    wr_check(REG_RSTDLY, 16'h003b, RSTDLY_MIN);
    $display("test settings done");
    wr_check(REG_LEVEL, 16'h0032, 16'h0032);
    wr_check(REG_DEFDLY, DLY_MIN, DLY_MIN);
    wr_check(REG_OPER, 16'h0001, 16'h0001);
    tgt_mag <= 16'h0032;
    cycles(5);
    check({15'h0000, start_out}, 16'h0000);
    tgt_mag <= 16'h0033;
    cycles(3);
    check({15'h0000, start_out}, 16'h0001);
    wait_trip(2000, n);
    in_range(n, 39 * MS - 5, 41 * MS + 5);
    check({15'h0000, start_out}, 16'h0001);
    rearm(REG_OPER, 16'h0001);
    cycles(3 * MS);
    check({15'h0000, trip_out}, 16'h0000);
    wait_trip(2000, n);
    in_range(n, 36 * MS - 5, 38 * MS + 5);
    $display("test definite done");
    tgt_mag <= 16'h0000;
    wr_check(REG_LEVEL, LEVEL_MIN, LEVEL_MIN);
    wr_check(REG_TMS, TMS_RST, TMS_RST);
    wr_check(REG_OPER, 16'h0003, 16'h0003);
    // twenty times the level: about 710 ms at multiplier 1.00
    tgt_mag <= 16'h00c8;
    wait_trip(20000, n);
    in_range(n, 13350, 15070);
    // forty times, multiplier 0.50: held at the twentyfold time, halved
    tgt_mag <= 16'h0190;
    rearm(REG_TMS, 16'h0032);
    wait_trip(20000, n);
    in_range(n, 6680, 7540);
    rearm(REG_TMS, TMS_MIN);
    wait_trip(2000, n);
    in_range(n, 39 * MS - 5, 41 * MS + 5);
    rd_check(REG_STATUS, 16'h0873);
    $display("test inverse done");
    finish_test();
  end
endmodule : tb
